//--- host_irq_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_irq_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       irq,
  output var  logic [7:0] irq_count
);
  // ----------------------------------------
  // Host side: counts each new interrupt request
  // ----------------------------------------
  logic irq_seen_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_seen_q <= 1'h0;
      irq_count  <= 8'h00;
    end else begin
      irq_seen_q <= irq;
      if (irq && !irq_seen_q) irq_count <= irq_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- interrupt_status_aggregator.v
// Overview of operation
// - Bus interrupt is high whenever any unmasked summary status bit is set, low when none.
// - A status bit sets only for events seen while its enable is already on.
// - Clearing follows the acknowledge mode bit of the global configuration.
// - Bit 31 reads one exactly while any pin status bit is set.
// - Bit 30 reads one exactly while any error status bit is set.
// - Bit 29 sets on frame timer expiry when enabled; cleared by acknowledge.
// - Bit 28 sets on selected frame trigger event when enabled; cleared by acknowledge.
// - Bits 16 to 19 set when that output group just updated, if enabled.
// - Bit 4 sets when sequencer finished its configured conversions, if enabled.
// - Bit 0 sets when sequencer DMA signals a completed buffer, if enabled.
// - Each of 20 pins has rise and fall enables, off at reset.
// - Enabled sequencer and DMA errors set error bits and stop sequencer or DMA.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "irq_agg_defines.vh"

module interrupt_status_aggregator (
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [11:0]           paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  input  wire [`PIN_COUNT-1:0] pin_levels,
  input  wire                  frame_timer_expired,
  input  wire                  frame_trigger_seen,
  input  wire                  out_group1_updated,
  input  wire                  out_group2_updated,
  input  wire                  out_group3_updated,
  input  wire                  out_group4_updated,
  input  wire                  seq_conv_done,
  input  wire                  seq_buffer_complete,
  input  wire                  seq_frame_fault,
  input  wire                  seq_timing_fault,
  input  wire                  seq_data_fault,
  input  wire                  seq_dma_fault,
  output reg                   irq,
  output reg                   seq_stop,
  output reg                   dma_stop
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Bits to clear on a completed access, by acknowledge mode
  function [31:0] clear_vec;
    input        sel;
    input        wr;
    input        rd_mode;
    input [31:0] wdata;
    input [31:0] rdata;
    begin
      if (sel && wr && !rd_mode) begin
        clear_vec = wdata;
      end else if (sel && !wr && rd_mode) begin
        clear_vec = rdata;
      end else begin
        clear_vec = `RST_ZERO;
      end
    end
  endfunction

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg                   ack_on_read_q;
  reg  [31:0]           irq_enable_q;
  reg  [31:0]           irq_mask_q;
  reg  [3:0]            err_enable_q;
  reg  [`PIN_COUNT-1:0] rise_en_q;
  reg  [`PIN_COUNT-1:0] fall_en_q;

  wire        setup   = psel & ~penable;
  wire        access  = psel & penable & pready;
  wire        wr_acc  = access & pwrite;
  wire        mapped;
  wire [31:0] rd_value;

  assign mapped = hit(paddr, `OFS_GLOBAL_CFG) | hit(paddr, `OFS_ERR_ENABLE) |
                  hit(paddr, `OFS_PIN_RISE_EN) | hit(paddr, `OFS_PIN_FALL_EN) |
                  hit(paddr, `OFS_PIN_STATUS) | hit(paddr, `OFS_IRQ_ENABLE) |
                  hit(paddr, `OFS_PENDING_SUMMARY) | hit(paddr, `OFS_ERR_STATUS) |
                  hit(paddr, `OFS_IRQ_MASK);

  // ----------------------------------------
  // Write strobes, one per writable register
  // ----------------------------------------
  wire        wr_cfg    = wr_acc & hit(paddr, `OFS_GLOBAL_CFG);
  wire        wr_err_en = wr_acc & hit(paddr, `OFS_ERR_ENABLE);
  wire        wr_rise   = wr_acc & hit(paddr, `OFS_PIN_RISE_EN);
  wire        wr_fall   = wr_acc & hit(paddr, `OFS_PIN_FALL_EN);
  wire        wr_enable = wr_acc & hit(paddr, `OFS_IRQ_ENABLE);
  wire        wr_mask   = wr_acc & hit(paddr, `OFS_IRQ_MASK);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_on_read_q <= 1'b0;
      irq_enable_q  <= `RST_ZERO;
      irq_mask_q    <= `RST_IRQ_MASK;
      err_enable_q  <= 4'h0;
      rise_en_q     <= {`PIN_COUNT{1'b0}};
      fall_en_q     <= {`PIN_COUNT{1'b0}};
    end else begin
      if (wr_cfg) begin
        ack_on_read_q <= pwdata[`BIT_ACK_MODE];
      end
      if (wr_enable) begin
        irq_enable_q <= pwdata & `MASK_SUMMARY_RC;
      end
      if (wr_mask) begin
        irq_mask_q <= pwdata;
      end
      if (wr_err_en) begin
        err_enable_q <= pwdata[`BIT_ERR_HI:`BIT_ERR_LO];
      end
      if (wr_rise) begin
        rise_en_q <= pwdata[`PIN_COUNT-1:0];
      end
      if (wr_fall) begin
        fall_en_q <= pwdata[`PIN_COUNT-1:0];
      end
    end
  end

  // ----------------------------------------
  // Acknowledge decode
  // ----------------------------------------
  // Clear-on-read clears only what the captured read data showed,
  // so a bit set between setup and access is not lost
  wire [31:0] sum_clr = clear_vec(access & hit(paddr, `OFS_PENDING_SUMMARY),
                                  pwrite, ack_on_read_q, pwdata, prdata);
  wire [31:0] pin_clr = clear_vec(access & hit(paddr, `OFS_PIN_STATUS),
                                  pwrite, ack_on_read_q, pwdata, prdata);
  wire [31:0] err_clr = clear_vec(access & hit(paddr, `OFS_ERR_STATUS),
                                  pwrite, ack_on_read_q, pwdata, prdata);

  // ----------------------------------------
  // Status sources
  // ----------------------------------------
  wire [7:0]            main_evt;
  wire [7:0]            main_en;
  wire [7:0]            main_clr;
  wire [7:0]            main_status;
  wire [3:0]            err_status;
  wire [`PIN_COUNT-1:0] pin_status;

  assign main_evt = {frame_timer_expired,
                     frame_trigger_seen,
                     out_group4_updated, out_group3_updated,
                     out_group2_updated, out_group1_updated,
                     seq_conv_done,
                     seq_buffer_complete};

  assign main_en  = {irq_enable_q[`BIT_FRAME_TIMER], irq_enable_q[`BIT_FRAME_TRIGGER],
                     irq_enable_q[`BIT_GROUP_HI:`BIT_GROUP_LO],
                     irq_enable_q[`BIT_CONV_DONE], irq_enable_q[`BIT_BUFFER_DONE]};

  assign main_clr = {sum_clr[`BIT_FRAME_TIMER], sum_clr[`BIT_FRAME_TRIGGER],
                     sum_clr[`BIT_GROUP_HI:`BIT_GROUP_LO],
                     sum_clr[`BIT_CONV_DONE], sum_clr[`BIT_BUFFER_DONE]};

  sticky_status #(
    .WIDTH    (8)
  ) u_main_status (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .evt      (main_evt),
    .en       (main_en),
    .clr      (main_clr),
    .status_q (main_status)
  );

  sticky_status #(
    .WIDTH    (4)
  ) u_err_status (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .evt      ({seq_frame_fault, seq_timing_fault, seq_data_fault, seq_dma_fault}),
    .en       (err_enable_q),
    .clr      (err_clr[`BIT_ERR_HI:`BIT_ERR_LO]),
    .status_q (err_status)
  );

  pin_edge_status u_pin_status (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pins     (pin_levels),
    .rise_en  (rise_en_q),
    .fall_en  (fall_en_q),
    .clr      (pin_clr[`PIN_COUNT-1:0]),
    .status_q (pin_status)
  );

  // ----------------------------------------
  // Summary word
  // ----------------------------------------
  wire        pin_events_summary = |pin_status;
  wire        err_events_summary = |err_status;
  reg  [31:0] summary;

  always @* begin
    summary                                 = `RST_ZERO;
    summary[`BIT_PIN_SUMMARY]               = pin_events_summary;
    summary[`BIT_ERR_SUMMARY]               = err_events_summary;
    summary[`BIT_FRAME_TIMER]               = main_status[7];
    summary[`BIT_FRAME_TRIGGER]             = main_status[6];
    summary[`BIT_GROUP_HI:`BIT_GROUP_LO]    = main_status[5:2];
    summary[`BIT_CONV_DONE]                 = main_status[1];
    summary[`BIT_BUFFER_DONE]               = main_status[0];
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = `RST_ZERO;
    if (hit(paddr, `OFS_GLOBAL_CFG)) begin
      rd_mux[`BIT_ACK_MODE] = ack_on_read_q;
    end else if (hit(paddr, `OFS_ERR_ENABLE)) begin
      rd_mux[`BIT_ERR_HI:`BIT_ERR_LO] = err_enable_q;
    end else if (hit(paddr, `OFS_PIN_RISE_EN)) begin
      rd_mux[`PIN_COUNT-1:0] = rise_en_q;
    end else if (hit(paddr, `OFS_PIN_FALL_EN)) begin
      rd_mux[`PIN_COUNT-1:0] = fall_en_q;
    end else if (hit(paddr, `OFS_PIN_STATUS)) begin
      rd_mux[`PIN_COUNT-1:0] = pin_status;
    end else if (hit(paddr, `OFS_IRQ_ENABLE)) begin
      rd_mux = irq_enable_q;
    end else if (hit(paddr, `OFS_PENDING_SUMMARY)) begin
      rd_mux = summary;
    end else if (hit(paddr, `OFS_ERR_STATUS)) begin
      rd_mux[`BIT_ERR_HI:`BIT_ERR_LO] = err_status;
    end else if (hit(paddr, `OFS_IRQ_MASK)) begin
      rd_mux = irq_mask_q;
    end
  end

  assign rd_value = rd_mux;

  // ----------------------------------------
  // APB answer: one wait-free access phase
  // ----------------------------------------
  // Read data is captured at setup so the outputs come from flops
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= `RST_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? `RST_ZERO : rd_value;
      pready  <= 1'b1;
      pslverr <= ~mapped;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // Mask resets to all ones, so the line follows every status bit by default
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(summary & irq_mask_q);
    end
  end

  // ----------------------------------------
  // Stop outputs
  // ----------------------------------------
  // Stops are levels: they stay up until software clears the error bit
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_stop <= 1'b0;
      dma_stop <= 1'b0;
    end else begin
      seq_stop <= |err_status[3:1];
      dma_stop <= err_status[0];
    end
  end

endmodule

`default_nettype wire

//--- irq_agg_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_agg_defines.vh"
module irq_agg_checker (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        seq_frame_fault,
  input wire logic        seq_timing_fault,
  input wire logic        seq_data_fault,
  input wire logic        seq_dma_fault,
  input wire logic        irq,
  input wire logic        seq_stop,
  input wire logic        dma_stop
);
  // ----------------------------------------
  // Bus and status relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd;
    pready && !pwrite;
  endsequence
  a_ready_setup: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_unmapped_zero: assert property (pslverr |-> prdata == 32'h00000000)
    else $error("unmapped data");
  a_summary_rsvd: assert property (s_rd ##0 paddr == `OFS_PENDING_SUMMARY
    |-> (prdata & 32'h0FF0FFEE) == 32'h00000000) else $error("reserved bit set");
  a_err_rsvd: assert property (s_rd ##0 paddr == `OFS_ERR_STATUS
    |-> (prdata & 32'hFFF0FFFF) == 32'h00000000) else $error("error reserved set");
  a_dma_stop_cause: assert property ($rose(dma_stop) |-> $past(seq_dma_fault, 2))
    else $error("dma stop without fault");
  a_seq_stop_cause: assert property ($rose(seq_stop)
    |-> $past(seq_frame_fault || seq_timing_fault || seq_data_fault, 2))
    else $error("seq stop without fault");
  // Pin summary adds no cycle, so the clearing access is two back; three back is also accepted
  a_irq_fall_cause: assert property ($fell(irq)
    |-> $past(psel && penable && pready, 2) || $past(psel && penable && pready, 3))
    else $error("irq fell without access");
endmodule
`default_nettype wire

//--- irq_agg_defines.vh
`ifndef IRQ_AGG_DEFINES_VH
`define IRQ_AGG_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_GLOBAL_CFG      12'h300
`define OFS_ERR_ENABLE      12'h370
`define OFS_PIN_RISE_EN     12'h374
`define OFS_PIN_FALL_EN     12'h378
`define OFS_PIN_STATUS      12'h37C
`define OFS_IRQ_ENABLE      12'h380
`define OFS_PENDING_SUMMARY 12'h384
`define OFS_ERR_STATUS      12'h388
`define OFS_IRQ_MASK        12'h38C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_PIN_SUMMARY     31
`define BIT_ERR_SUMMARY     30
`define BIT_FRAME_TIMER     29
`define BIT_FRAME_TRIGGER   28
`define BIT_GROUP_LO        16
`define BIT_GROUP_HI        19
`define BIT_CONV_DONE       4
`define BIT_BUFFER_DONE     0
`define BIT_ACK_MODE        0
`define BIT_ERR_LO          16
`define BIT_ERR_DMA         16
`define BIT_ERR_HI          19
`define PIN_COUNT           20

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define RST_ZERO            32'h00000000
`define RST_IRQ_MASK        32'hFFFFFFFF
`define MASK_SUMMARY_RC     32'h300F0011
`define MASK_PIN            32'h000FFFFF
`define MASK_ERR            32'h000F0000

`endif

//--- pin_edge_status.v
`timescale 1ns/10ps
`default_nettype none
`include "irq_agg_defines.vh"

module pin_edge_status (
  input  wire                     sys_clk,
  input  wire                     rst_n,
  input  wire [`PIN_COUNT-1:0]    pins,
  input  wire [`PIN_COUNT-1:0]    rise_en,
  input  wire [`PIN_COUNT-1:0]    fall_en,
  input  wire [`PIN_COUNT-1:0]    clr,
  output reg  [`PIN_COUNT-1:0]    status_q
);

  // ----------------------------------------
  // Two-stage synchroniser plus history
  // ----------------------------------------
  reg  [`PIN_COUNT-1:0] meta_q;
  reg  [`PIN_COUNT-1:0] sync_q;
  reg  [`PIN_COUNT-1:0] prev_q;
  wire [`PIN_COUNT-1:0] rise;
  wire [`PIN_COUNT-1:0] fall;
  wire [`PIN_COUNT-1:0] status_d;

  // Edges are judged on synchronised samples only, meta_q is never looked at
  assign rise     = sync_q & ~prev_q;
  assign fall     = ~sync_q & prev_q;
  assign status_d = (status_q & ~clr) | (rise & rise_en) | (fall & fall_en);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= {`PIN_COUNT{1'b0}};
      sync_q   <= {`PIN_COUNT{1'b0}};
      prev_q   <= {`PIN_COUNT{1'b0}};
      status_q <= {`PIN_COUNT{1'b0}};
    end else begin
      meta_q   <= pins;
      sync_q   <= meta_q;
      prev_q   <= sync_q;
      status_q <= status_d;
    end
  end

endmodule

`default_nettype wire

//--- sticky_status.v
`timescale 1ns/10ps
`default_nettype none

module sticky_status #(
  parameter WIDTH = 8
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] evt,
  input  wire [WIDTH-1:0] en,
  input  wire [WIDTH-1:0] clr,
  output reg  [WIDTH-1:0] status_q
);

  // ----------------------------------------
  // Sticky bits, set beats clear
  // ----------------------------------------
  wire [WIDTH-1:0] status_d;

  // Enable is sampled with the event itself, never applied later
  assign status_d = (status_q & ~clr) | (evt & en);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= {WIDTH{1'b0}};
    end else begin
      status_q <= status_d;
    end
  end

endmodule

`default_nettype wire

//--- test_interrupt_status_aggregator.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_agg_defines.vh"
module test_interrupt_status_aggregator;
  logic        sys_clk = 1'h0;
  logic        rst_n   = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [19:0] pins    = 20'h00000;
  logic [11:0] ev      = 12'h000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        seq_stop;
  logic        dma_stop;
  logic [7:0]  irq_count;
  logic [31:0] q;
  logic        e;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          bits [8]    = '{29, 28, 16, 17, 18, 19, 4, 0};
  localparam logic [11:0] a_sum = `OFS_PENDING_SUMMARY;
  // ----------------------------------------
  // Design, host model and clock
  // ----------------------------------------
  always #25 sys_clk = ~sys_clk;
  interrupt_status_aggregator i_interrupt_status_aggregator (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_levels(pins), .frame_timer_expired(ev[0]), .frame_trigger_seen(ev[1]),
    .out_group1_updated(ev[2]), .out_group2_updated(ev[3]), .out_group3_updated(ev[4]),
    .out_group4_updated(ev[5]), .seq_conv_done(ev[6]), .seq_buffer_complete(ev[7]),
    .seq_frame_fault(ev[8]), .seq_timing_fault(ev[9]), .seq_data_fault(ev[10]),
    .seq_dma_fault(ev[11]), .irq(irq), .seq_stop(seq_stop), .dma_stop(dma_stop));
  host_irq_model i_host_irq_model (
    .sys_clk(sys_clk), .rst_n(rst_n), .irq(irq), .irq_count(irq_count));
  // ----------------------------------------
  // Bus, event and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Answer is taken at the rising edge where pready is sampled high, before its updates
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int   n;
    logic r;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      r = pready;
      n++;
      if (n > 20) begin
        miscompares++;
        end_sim();
      end
    end while (r !== 1'h1);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'h0, a, 32'h00000000);
    chk(q, exp, nm);
  endtask
  task automatic pulse(input int i);
    @(posedge sys_clk);
    ev[i] <= 1'h1;
    @(posedge sys_clk);
    ev <= 12'h000;
  endtask
  task automatic chk_out(input logic [31:0] exp, input string nm);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({29'h0, seq_stop, dma_stop, irq}, exp, nm);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    rd(a_sum, 32'h00000000, "summary");
    rd(`OFS_PIN_RISE_EN, 32'h00000000, "rise_en");
    rd(`OFS_PIN_FALL_EN, 32'h00000000, "fall_en");
    rd(`OFS_IRQ_MASK, 32'hFFFFFFFF, "mask");
    for (int i = 0; i < 12; i++) pulse(i);
    rd(a_sum, 32'h00000000, "summary");
    rd(`OFS_ERR_STATUS, 32'h00000000, "err");
    apb(1'h1, `OFS_IRQ_ENABLE, 32'hFFFFFFFF);
    rd(`OFS_IRQ_ENABLE, 32'h300F0011, "enable");
    apb(1'h1, a_sum, 32'hFFFFFFFF);
    rd(a_sum, 32'h00000000, "summary");
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      rd(a_sum, 32'h00000001 << bits[i], "event bit");
      chk_out(32'h00000001, "irq");
      apb(1'h1, a_sum, 32'h00000001 << bits[i]);
      rd(a_sum, 32'h00000000, "acked");
      chk_out(32'h00000000, "irq");
    end
    pulse(0);
    fork
      apb(1'h1, a_sum, 32'h20000000);
      begin
        repeat (2) @(posedge sys_clk);
        ev[0] <= 1'h1;
        @(posedge sys_clk);
        ev <= 12'h000;
      end
    join
    rd(a_sum, 32'h20000000, "set over ack");
    apb(1'h1, `OFS_IRQ_MASK, 32'h00000000);
    chk_out(32'h00000000, "masked irq");
    apb(1'h1, `OFS_IRQ_MASK, 32'hFFFFFFFF);
    chk_out(32'h00000001, "unmasked irq");
    apb(1'h1, a_sum, 32'h20000000);
    apb(1'h1, `OFS_PIN_RISE_EN, 32'h00000001);
    pins <= 20'h80001;
    repeat (5) @(posedge sys_clk);
    rd(`OFS_PIN_STATUS, 32'h00000001, "pin rise");
    rd(a_sum, 32'h80000000, "pin summary");
    apb(1'h1, `OFS_PIN_STATUS, 32'h00000001);
    apb(1'h1, `OFS_PIN_FALL_EN, 32'hFFFFFFFF);
    rd(`OFS_PIN_FALL_EN, 32'h000FFFFF, "fall_en");
    pins <= 20'h00000;
    repeat (5) @(posedge sys_clk);
    rd(`OFS_PIN_STATUS, 32'h00080001, "pin fall");
    apb(1'h1, `OFS_PIN_STATUS, 32'hFFFFFFFF);
    rd(a_sum, 32'h00000000, "pin summary");
    apb(1'h1, `OFS_ERR_ENABLE, 32'h000F0000);
    pulse(11);
    rd(`OFS_ERR_STATUS, 32'h00010000, "dma err");
    rd(a_sum, 32'h40000000, "err summary");
    chk_out(32'h00000003, "dma stop");
    for (int i = 8; i < 11; i++) pulse(i);
    rd(`OFS_ERR_STATUS, 32'h000F0000, "seq err");
    chk_out(32'h00000007, "seq stop");
    apb(1'h1, `OFS_ERR_STATUS, 32'hFFFFFFFF);
    rd(a_sum, 32'h00000000, "err summary");
    chk_out(32'h00000000, "stops");
    rd(12'h004, 32'h00000000, "unmapped");
    chk({31'h0, e}, 32'h00000001, "pslverr");
    apb(1'h1, `OFS_GLOBAL_CFG, 32'h00000001);
    pulse(7);
    apb(1'h1, a_sum, 32'h00000001);
    rd(a_sum, 32'h00000001, "read clear");
    rd(a_sum, 32'h00000000, "read clear");
    chk_out(32'h00000000, "irq");
    chk({24'h0, irq_count}, 32'h0000000E, "irq count");
    end_sim();
  end
endmodule
bind interrupt_status_aggregator irq_agg_checker i_irq_agg_checker (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .seq_frame_fault(seq_frame_fault), .seq_timing_fault(seq_timing_fault),
  .seq_data_fault(seq_data_fault), .seq_dma_fault(seq_dma_fault), .irq(irq),
  .seq_stop(seq_stop), .dma_stop(dma_stop));
`default_nettype wire
